// ==== logic/pbfs_apb_slave.sv ====
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// APB slave front end, zero wait states
// ****************************************************************
module pbfs_apb_slave (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [pbfs_pkg::ADDR_W-1:0] paddr,
	input wire logic [pbfs_pkg::DATA_W-1:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic pready,
	output logic [pbfs_pkg::DATA_W-1:0] prdata,
	output logic pslverr,
	// Register side
	pbfs_bus_if.slave bus
);
	import pbfs_pkg::*;

	logic [7:0] rdata_ff; // Read byte captured in setup
	logic err_ff; // Unmapped or misaligned access
	logic setup; // Setup phase of a transfer
	logic bad_addr; // Address outside word-aligned map

	assign setup = psel & ~penable;
	assign bad_addr = (paddr[1:0] != 2'b00) | (paddr[11:10] != 2'b00);
	assign bus.idx = paddr[9:2];
	assign bus.wdata = pwdata[7:0];
	// Write lands on the access edge only, low lane only
	assign bus.wr_stb = psel & penable & pwrite & pstrb[0] & ~err_ff;
	assign pready = 1'b1;
	assign prdata = {24'h000000, rdata_ff};
	assign pslverr = psel & penable & err_ff;

	// Capture answer during setup so the access phase sees flops
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rdata_ff <= 8'h00;
			err_ff <= 1'b0;
		end else if (setup) begin
			rdata_ff <= (pwrite | bad_addr) ? 8'h00 : bus.rdata;
			err_ff <= bad_addr | ~bus.hit;
		end
	end
endmodule : pbfs_apb_slave
`default_nettype wire

// ==== logic/pbfs_sticky.sv ====
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// Rising-edge catcher with write-one-to-clear flags
// ****************************************************************
module pbfs_sticky #(
	parameter int W = 5
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Live levels and clear request
	input wire logic [W-1:0] live,
	input wire logic [W-1:0] clr,
	// Sticky flags
	output logic [W-1:0] flags
);
	logic [W-1:0] prev_ff; // Level seen last cycle
	logic [W-1:0] flag_ff; // Caught events
	logic [W-1:0] rise; // New event this cycle

	assign rise = live & ~prev_ff;
	assign flags = flag_ff;

	// Remember last level for edge detection
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			prev_ff <= '0;
		end else begin
			prev_ff <= live;
		end
	end

	// Set beats clear so a coincident event is never lost
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			flag_ff <= '0;
		end else begin
			flag_ff <= (flag_ff & ~clr) | rise;
		end
	end

	AST_SET_WINS: assert property (@(posedge clk) disable iff (!rst_n)
		(rise != '0) |=> ((flags & $past(rise)) == $past(rise)))
		else $error("event lost against clear");
endmodule : pbfs_sticky
`default_nettype wire

// ==== logic/pbfs_top.sv ====
`timescale 1ns/1ps
`default_nettype none
// How it works
// - Page select register sits at index 0
// - Eight-bit page, any value, resets page 0
// - Sink enable bit gates the sink current
// - Sink current is level times 4.3 mA
// - Global status read-only, low nibble reserved
// - Bit 7 shows audio interface clock error
// - Bit 6 shows PLL lock
// - Bit 5 shows boost/bias over-temperature
// - Bit 4 shows boost/bias over-current
// - Read-only channel summary on page 1
// - Bits 7..2 channel faults, bit 1 battery
module pbfs_top (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [pbfs_pkg::ADDR_W-1:0] paddr,
	input wire logic [pbfs_pkg::DATA_W-1:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic pready,
	output logic [pbfs_pkg::DATA_W-1:0] prdata,
	output logic pslverr,
	// Live fault detectors
	input wire logic audio_serial_interface_clk_err,
	input wire logic pll_locked,
	input wire logic bias_over_temp,
	input wire logic bias_over_curr,
	input wire logic [5:0] chan_fault,
	input wire logic vbat_short_fault,
	// Page and bias load controls
	output logic [pbfs_pkg::REG_W-1:0] page_sel,
	output logic load_sink_enable,
	output logic [2:0] load_sink_level,
	output logic [8:0] load_sink_ma_x10,
	// Interrupt
	output logic irq
);
	import pbfs_pkg::*;

	// ****************************************************************
	// Declarations
	// ****************************************************************
	pbfs_bus_if bus (); // Decoded register access

	logic [7:0] page_ff; // Selected page
	logic sink_en_ff; // Load sink enable
	logic [2:0] sink_lvl_ff; // Load sink level code
	logic [8:0] sink_ma_ff; // Sink current, 0.1 mA units
	logic [8:0] nxt_sink_ma; // Next sink current
	logic [3:0] gstat_ff; // Global status bits 7..4
	logic [6:0] chsum_ff; // Channel summary bits 7..1
	logic [IRQ_W-1:0] mask_ff; // Interrupt mask
	logic [IRQ_W-1:0] irq_flags; // Sticky event flags
	logic [IRQ_W-1:0] irq_live; // Levels that raise events
	logic [IRQ_W-1:0] irq_clr; // Write-one-to-clear request
	logic on_fault_page; // Page 1 selected
	logic wr_page; // Write to page select
	logic wr_bias; // Write to bias load register
	logic wr_mask; // Write to interrupt mask
	logic wr_istat; // Write to interrupt status

	// ****************************************************************
	// Bus front end
	// ****************************************************************
	pbfs_apb_slave u_apb (
		.pclk(pclk),
		.presetn(presetn),
		.psel(psel),
		.penable(penable),
		.pwrite(pwrite),
		.paddr(paddr),
		.pwdata(pwdata),
		.pstrb(pstrb),
		.pready(pready),
		.prdata(prdata),
		.pslverr(pslverr),
		.bus(bus.slave)
	);

	// ****************************************************************
	// Write decode
	// ****************************************************************
	// Page and interrupt registers answer on every page
	assign on_fault_page = (page_ff == FAULT_PAGE);
	assign wr_page = bus.wr_stb & (bus.idx == IDX_PAGE);
	assign wr_mask = bus.wr_stb & (bus.idx == IDX_IRQ_MASK);
	assign wr_istat = bus.wr_stb & (bus.idx == IDX_IRQ_STAT);
	// Bias register only reachable while page 1 is selected
	assign wr_bias = bus.wr_stb & on_fault_page & (bus.idx == IDX_BIAS);

	// ****************************************************************
	// Page select
	// ****************************************************************
	// Whole byte is the page number, no value is refused
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			page_ff <= PAGE_RST;
		end else if (wr_page) begin
			page_ff <= bus.wdata;
		end
	end

	assign page_sel = page_ff;

	// ****************************************************************
	// Bias load sink configuration
	// ****************************************************************
	// Only bits 7..4 are stored; the low nibble is dropped
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sink_en_ff <= SINK_EN_RST;
			sink_lvl_ff <= SINK_LVL_RST;
		end else if (wr_bias) begin
			sink_en_ff <= bus.wdata[SINK_EN_BIT];
			sink_lvl_ff <= bus.wdata[SINK_LVL_MSB:SINK_LVL_LSB];
		end
	end

	// Current is linear in the level; enable off forces zero.
	// Software is expected to turn this on for single-ended
	// AC-coupled inputs; nothing here enforces that.
	always_comb begin
		if (sink_en_ff) begin
			nxt_sink_ma = {6'h00, sink_lvl_ff} * SINK_STEP_X10;
		end else begin
			nxt_sink_ma = 9'h000;
		end
	end

	// Current setting registered so the analog side sees no glitch
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sink_ma_ff <= 9'h000;
		end else begin
			sink_ma_ff <= nxt_sink_ma;
		end
	end

	assign load_sink_enable = sink_en_ff;
	assign load_sink_level = sink_lvl_ff;
	assign load_sink_ma_x10 = sink_ma_ff;

	// ****************************************************************
	// Live status capture
	// ****************************************************************
	// Status follows the detectors with one cycle of delay; it is
	// a live view, so a fault that clears also clears the bit
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			gstat_ff <= GSTAT_RST;
		end else begin
			gstat_ff[3] <= audio_serial_interface_clk_err;
			gstat_ff[2] <= pll_locked;
			gstat_ff[1] <= bias_over_temp;
			gstat_ff[0] <= bias_over_curr;
		end
	end

	// Channel 1 lands in bit 7, channel 6 in bit 2
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			chsum_ff <= CHSUM_RST;
		end else begin
			chsum_ff[6] <= chan_fault[0];
			chsum_ff[5] <= chan_fault[1];
			chsum_ff[4] <= chan_fault[2];
			chsum_ff[3] <= chan_fault[3];
			chsum_ff[2] <= chan_fault[4];
			chsum_ff[1] <= chan_fault[5];
			chsum_ff[0] <= vbat_short_fault;
		end
	end

	// ****************************************************************
	// Interrupts
	// ****************************************************************
	// A fresh global condition, or the OR of the channel summary going high, raises a flag;
	// pll lock rising is reported too, as a lock event
	assign irq_live = {gstat_ff, |chsum_ff};
	assign irq_clr = wr_istat ? bus.wdata[7:IRQ_LSB] : '0;

	pbfs_sticky #(
		.W(IRQ_W)
	) u_sticky (
		.clk(pclk),
		.rst_n(presetn),
		.live(irq_live),
		.clr(irq_clr),
		.flags(irq_flags)
	);

	// Mask keeps the same layout as the flags
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mask_ff <= IRQ_MASK_RST;
		end else if (wr_mask) begin
			mask_ff <= bus.wdata[7:IRQ_LSB];
		end
	end

	// Level output, drops as soon as the flag is cleared
	assign irq = |(irq_flags & mask_ff);

	// ****************************************************************
	// Read decode
	// ****************************************************************
	// Page 1 registers vanish on other pages and answer as
	// unmapped; reserved bits are constant zero
	always_comb begin
		bus.rdata = 8'h00;
		bus.hit = 1'b1;
		case (bus.idx)
			IDX_PAGE: begin
				bus.rdata = page_ff;
			end
			IDX_IRQ_STAT: begin
				bus.rdata = {irq_flags, 3'b000};
			end
			IDX_IRQ_MASK: begin
				bus.rdata = {mask_ff, 3'b000};
			end
			IDX_BIAS: begin
				bus.hit = on_fault_page;
				if (on_fault_page) begin
					bus.rdata = {sink_en_ff, sink_lvl_ff, 4'h0};
				end
			end
			IDX_GSTAT: begin
				bus.hit = on_fault_page;
				if (on_fault_page) begin
					bus.rdata = {gstat_ff, 4'h0};
				end
			end
			IDX_CHSUM: begin
				bus.hit = on_fault_page;
				if (on_fault_page) begin
					bus.rdata = {chsum_ff, 1'b0};
				end
			end
			default: begin
				bus.hit = 1'b0;
			end
		endcase
	end

	// ****************************************************************
	// Checks
	// ****************************************************************
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	// A page write followed by its effect
	sequence s_page_wr;
		wr_page;
	endsequence

	sequence s_page_seen;
		##1 page_sel == $past(bus.wdata);
	endsequence

	// A read of a page 1 register while another page is set
	sequence s_off_page_rd;
		!on_fault_page && (bus.idx == IDX_GSTAT || bus.idx == IDX_CHSUM);
	endsequence

	AST_PAGE_WRITE: assert property (
		s_page_wr |-> s_page_seen)
		else $error("page write not taken");

	AST_PAGE_HOLD: assert property (
		!wr_page |=> $stable(page_sel))
		else $error("page changed without a write");

	AST_SINK_OFF: assert property (
		!load_sink_enable ##1 !$changed(load_sink_enable)
		|-> load_sink_ma_x10 == 9'h000)
		else $error("sink current while disabled");

	AST_SINK_LEVEL: assert property (
		load_sink_enable && $stable(load_sink_level)
		|=> load_sink_ma_x10 == 9'(43 * $past(load_sink_level)))
		else $error("sink current not level times step");

	AST_SERIAL_CLK_ERR: assert property (
		audio_serial_interface_clk_err |=> gstat_ff[3])
		else $error("clock error not shown");

	AST_PLL_LOCK: assert property (
		##1 gstat_ff[2] == $past(pll_locked))
		else $error("lock status wrong");

	AST_OVER_TEMP: assert property (
		bias_over_temp ##1 !bias_over_temp |-> gstat_ff[1] ##1 !gstat_ff[1])
		else $error("over-temperature status wrong");

	AST_OVER_CURR: assert property (
		##1 gstat_ff[0] == $past(bias_over_curr))
		else $error("over-current status wrong");

	AST_RSVD_ZERO: assert property (
		on_fault_page && bus.idx == IDX_GSTAT |-> bus.rdata[3:0] == 4'h0)
		else $error("reserved status bits not zero");

	AST_SUMMARY: assert property (
		##1 chsum_ff == $past({chan_fault[0], chan_fault[1],
			chan_fault[2], chan_fault[3], chan_fault[4],
			chan_fault[5], vbat_short_fault}))
		else $error("channel summary mapping wrong");

	AST_OFF_PAGE: assert property (
		s_off_page_rd |-> !bus.hit && bus.rdata == 8'h00)
		else $error("page 1 register visible off page");

	AST_BIAS_RSVD: assert property (
		on_fault_page && bus.idx == IDX_BIAS |-> bus.rdata[3:0] == 4'h0)
		else $error("bias reserved bits not zero");

	AST_IRQ_LEVEL: assert property (
		irq == ((irq_flags & mask_ff) != '0))
		else $error("interrupt level wrong");
endmodule : pbfs_top
`default_nettype wire

// ==== shared/pbfs_bus_if.sv ====
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// Internal register access carrier
// ****************************************************************
interface pbfs_bus_if;
	logic wr_stb; // One-cycle write pulse
	logic [7:0] idx; // Register index
	logic [7:0] wdata; // Low write byte
	logic [7:0] rdata; // Read value for idx
	logic hit; // Index maps to a register now
	modport slave (output wr_stb, idx, wdata, input rdata, hit);
	modport regs (input wr_stb, idx, wdata, output rdata, hit);
endinterface : pbfs_bus_if
`default_nettype wire

// ==== shared/pbfs_pkg.sv ====
`default_nettype none
// ****************************************************************
// Register map, field layout and reset values
// ****************************************************************
package pbfs_pkg;
	// Bus geometry: one register per aligned 32-bit word
	localparam int ADDR_W = 12;
	localparam int DATA_W = 32;
	localparam int REG_W = 8;
	// Register indices; byte address is four times the index
	localparam logic [7:0] IDX_PAGE = 8'h00;
	localparam logic [7:0] IDX_BIAS = 8'h16;
	localparam logic [7:0] IDX_GSTAT = 8'h2c;
	localparam logic [7:0] IDX_CHSUM = 8'h2d;
	localparam logic [7:0] IDX_IRQ_STAT = 8'h40;
	localparam logic [7:0] IDX_IRQ_MASK = 8'h41;
	// Page that holds the bias and fault registers
	localparam logic [7:0] FAULT_PAGE = 8'h01;
	// Reset values
	localparam logic [7:0] PAGE_RST = 8'h00;
	localparam logic SINK_EN_RST = 1'b0;
	localparam logic [2:0] SINK_LVL_RST = 3'h0;
	localparam logic [3:0] GSTAT_RST = 4'h0;
	localparam logic [6:0] CHSUM_RST = 7'h00;
	// Bias load register fields
	localparam int SINK_EN_BIT = 7;
	localparam int SINK_LVL_MSB = 6;
	localparam int SINK_LVL_LSB = 4;
	// Sink current step, in units of 0.1 mA (4.3 mA)
	localparam logic [8:0] SINK_STEP_X10 = 9'h02b;
	// Global status fields live in bits 7..4
	localparam int GSTAT_LSB = 4;
	// Channel summary fields live in bits 7..1
	localparam int CHSUM_LSB = 1;
	// Interrupt flags sit in bits 7..3 of status and mask
	localparam int IRQ_W = 5;
	localparam int IRQ_LSB = 3;
	localparam logic [4:0] IRQ_MASK_RST = 5'h00;
endpackage : pbfs_pkg
`default_nettype wire

// ==== testbench/pbfs_top_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// Self-checking bench for the page-1 bias and fault registers
// ****************************************************************
module pbfs_top_tb;
	import pbfs_pkg::*;
	// One expected APB outcome, queued by the driver
	typedef struct {
		logic wr;
		logic [31:0] data;
		logic err;
	} pbfs_note_t;
	// Clock, reset and APB
	logic pclk;
	logic presetn;
	logic psel, penable, pwrite, pready, pslverr;
	logic [ADDR_W-1:0] paddr;
	logic [DATA_W-1:0] pwdata, prdata;
	logic [3:0] pstrb;
	// Detector levels and controls
	logic [3:0] gdet; // Clock error, lock, over-temp, over-current
	logic [5:0] chan_fault;
	logic vbat_short_fault, load_sink_enable, irq;
	logic [REG_W-1:0] page_sel;
	logic [2:0] load_sink_level;
	logic [8:0] load_sink_ma_x10;
	// Bench state
	int fails;
	int checks_done;
	int seed;
	pbfs_note_t notes[$];
	pbfs_note_t cur;
	logic [31:0] d;
	logic [7:0] v, exp8, f;
	logic [4:0] src;

	pbfs_top i_dut (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
		.pready(pready), .prdata(prdata), .pslverr(pslverr),
		.audio_serial_interface_clk_err(gdet[3]), .pll_locked(gdet[2]),
		.bias_over_temp(gdet[1]), .bias_over_curr(gdet[0]),
		.chan_fault(chan_fault), .vbat_short_fault(vbat_short_fault),
		.page_sel(page_sel), .load_sink_enable(load_sink_enable),
		.load_sink_level(load_sink_level),
		.load_sink_ma_x10(load_sink_ma_x10), .irq(irq)
	);

	// ****************************************************************
	// Clock, compare and bus tasks
	// ****************************************************************
	initial begin
		pclk = 1'b0;
		forever #2 pclk = ~pclk;
	end

	// Counted compare; case inequality so unknowns never match
	task automatic chk(input string name, input logic [31:0] exp,
		input logic [31:0] got);
		checks_done++;
		if (got !== exp) begin
			fails++;
			$display("ERROR %s expected %h seen %h", name, exp, got);
		end
	endtask : chk

	// One APB transfer; the expected outcome goes on the queue
	task automatic apb(input logic wr, input logic [11:0] addr,
		input logic [31:0] data, input logic [31:0] exp, input logic err);
		pbfs_note_t n;
		n.wr = wr;
		n.data = exp;
		n.err = err;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= addr;
		pwdata <= data;
		notes.push_back(n);
		@(posedge pclk);
		penable <= 1'b1;
		// Hold the request until pready is seen; only the watchdog
		// ends a wait that never completes
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic end_sim();
		if (fails == 0 && checks_done > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : end_sim

	// Watcher: every completed transfer consumes the oldest note
	always @(posedge pclk) begin
		if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1) begin
			if (notes.size() == 0) begin
				fails++;
				$display("ERROR queue expected 1 seen 0");
			end else begin
				cur = notes.pop_front();
				chk("pslverr", {31'h0, cur.err}, {31'h0, pslverr});
				if (!cur.wr) chk("prdata", cur.data, prdata);
			end
		end
	end

	// Watchdog: far beyond the few hundred cycles the run needs
	initial begin
		repeat (20000) @(posedge pclk);
		fails++;
		end_sim();
	end

	// ****************************************************************
	// Main sequence
	// ****************************************************************
	initial begin
		seed = 32'h5668bd52;
		{psel, penable, pwrite, presetn} = 4'h0;
		paddr = 12'h000;
		pwdata = 32'h0;
		pstrb = 4'hf;
		gdet = 4'h0;
		chan_fault = 6'h00;
		vbat_short_fault = 1'b0;
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		chk("page_sel", 32'h0, {24'h0, page_sel});
		apb(1'b0, 12'h000, 32'h0, 32'h0, 1'b0);
		apb(1'b0, 12'h058, 32'h0, 32'h0, 1'b1);
		// Any page value is stored; upper write bits dropped
		for (int i = 0; i < 4; i++) begin
			d = $random(seed);
			if (i == 0) d[7:0] = 8'hff;
			v = d[7:0];
			apb(1'b1, 12'h000, d, 32'h0, 1'b0);
			apb(1'b0, 12'h000, 32'h0, {24'h0, v}, 1'b0);
			chk("page_sel", {24'h0, v}, {24'h0, page_sel});
		end
		// A write without its byte strobe leaves the page alone
		pstrb <= 4'he;
		apb(1'b1, 12'h000, 32'h01, 32'h0, 1'b0);
		pstrb <= 4'hf;
		apb(1'b0, 12'h000, 32'h0, {24'h0, v}, 1'b0);
		apb(1'b1, 12'h000, 32'h01, 32'h0, 1'b0);
		// Every level with the sink off and on
		for (int i = 0; i < 16; i++) begin
			d = $random(seed);
			d[7:4] = i[3:0];
			exp8 = {d[7:4], 4'h0};
			apb(1'b1, 12'h058, d, 32'h0, 1'b0);
			apb(1'b0, 12'h058, 32'h0, {24'h0, exp8}, 1'b0);
			chk("load_sink_enable", {31'h0, d[7]}, {31'h0, load_sink_enable});
			chk("load_sink_level", {29'h0, d[6:4]}, {29'h0, load_sink_level});
			chk("load_sink_ma_x10", {23'h0, d[7] ? 9'(d[6:4]) * 9'h02b : 9'h000},
				{23'h0, load_sink_ma_x10});
		end
		// Live status and channel summary follow the detectors
		for (int i = 0; i < 8; i++) begin
			d = $random(seed);
			gdet <= d[3:0];
			chan_fault <= d[9:4];
			vbat_short_fault <= d[10];
			repeat (2) @(posedge pclk);
			apb(1'b0, 12'h0b0, 32'h0, {24'h0, d[3:0], 4'h0}, 1'b0);
			apb(1'b0, 12'h0b4, 32'h0, {24'h0, d[4], d[5], d[6], d[7], d[8],
				d[9], d[10], 1'b0}, 1'b0);
			apb(1'b1, 12'h0b0, 32'hff, 32'h0, 1'b0);
			apb(1'b1, 12'h0b4, 32'hff, 32'h0, 1'b0);
		end
		// Away from page 1 the page-1 registers are refused
		apb(1'b1, 12'h000, 32'h0, 32'h0, 1'b0);
		apb(1'b0, 12'h0b4, 32'h0, 32'h0, 1'b1);
		apb(1'b1, 12'h058, 32'h10, 32'h0, 1'b1);
		apb(1'b1, 12'h000, 32'h01, 32'h0, 1'b0);
		apb(1'b0, 12'h058, 32'h0, {24'h0, exp8}, 1'b0);
		// Unmapped and misaligned addresses
		apb(1'b0, 12'h3fc, 32'h0, 32'h0, 1'b1);
		apb(1'b0, 12'h059, 32'h0, 32'h0, 1'b1);
		// Interrupts: settle, clear, then each source in turn
		gdet <= 4'h0;
		chan_fault <= 6'h00;
		vbat_short_fault <= 1'b0;
		repeat (3) @(posedge pclk);
		apb(1'b1, 12'h100, 32'hf8, 32'h0, 1'b0);
		apb(1'b0, 12'h100, 32'h0, 32'h0, 1'b0);
		for (int i = 0; i < 5; i++) begin
			src = 5'h01 << i;
			f = 8'h08 << i;
			gdet <= src[4:1];
			chan_fault <= {src[0], 5'h00};
			repeat (3) @(posedge pclk);
			chk("irq", 32'h0, {31'h0, irq});
			apb(1'b0, 12'h100, 32'h0, {24'h0, f}, 1'b0);
			apb(1'b1, 12'h104, {24'h0, f}, 32'h0, 1'b0);
			apb(1'b0, 12'h104, 32'h0, {24'h0, f}, 1'b0);
			chk("irq", 32'h1, {31'h0, irq});
			gdet <= 4'h0;
			chan_fault <= 6'h00;
			apb(1'b1, 12'h100, {24'h0, f}, 32'h0, 1'b0);
			@(posedge pclk);
			chk("irq", 32'h0, {31'h0, irq});
			apb(1'b0, 12'h100, 32'h0, 32'h0, 1'b0);
			apb(1'b1, 12'h104, 32'h0, 32'h0, 1'b0);
		end
		// A second reset returns the page to zero
		apb(1'b1, 12'h000, 32'h07, 32'h0, 1'b0);
		@(posedge pclk);
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		chk("page_sel", 32'h0, {24'h0, page_sel});
		presetn <= 1'b1;
		apb(1'b0, 12'h000, 32'h0, 32'h0, 1'b0);
		repeat (2) @(posedge pclk);
		end_sim();
	end
endmodule : pbfs_top_tb
`default_nettype wire
